/* File: rtl/dac_channel_ctrl.sv */
// broadcast accept mask, soft clear, clear pin mask and clear code control
`default_nettype none
// Operation
// RULE1: a channel whose broadcast accept bit is 0 is left untouched by broadcast writes.
// RULE2: a channel whose broadcast accept bit is 1 takes every broadcast write.
// RULE3: sixteen read/write broadcast accept bits, one per channel, all reset to 1.
// RULE4: the soft clear register at offset Ch is 16 bits read/write and resets to 0000h.
// RULE5: writing 1 to a channel's soft clear bit puts that channel in the clear state.
// RULE6: a channel in the clear state drives its stored clear code instead of its data code.
// RULE7: writing 0 to a soft clear bit returns the channel to driving its data code.
// RULE8: a write of the broadcast clear code loads its 12-bit code into every accepting channel.
// RULE9: the clear pin acts on a channel only while that channel's pin ignore bit is 0.
// RULE10: bit n of each register controls channel n alone, independent of all others.
module dac_channel_ctrl (
	input  wire logic                                   mclk_i,
	input  wire logic                                   nrst_i,
	input  wire logic                                   reg_wr_i,
	input  wire logic                                   reg_rd_i,
	input  wire logic [dac_ctrl_pkg::ADDR_W-1:0]        reg_addr_i,
	input  wire logic [dac_ctrl_pkg::REG_W-1:0]         reg_wdata_i,
	input  wire logic                                   multi_function_pin_i,
	input  wire logic                                   broadcast_data_wr_i,
	input  wire logic [dac_ctrl_pkg::CODE_W-1:0]        broadcast_data_i,
	input  wire logic [dac_ctrl_pkg::ALL_CODES_W-1:0]   data_code_i,
	output logic      [dac_ctrl_pkg::REG_W-1:0]         reg_rdata_o,
	output logic                                        reg_rvalid_o,
	output logic      [dac_ctrl_pkg::CHANNELS-1:0]      clear_active_o,
	output logic      [dac_ctrl_pkg::ALL_CODES_W-1:0]   dac_code_o,
	output logic      [dac_ctrl_pkg::CHANNELS-1:0]      broadcast_load_o,
	output logic      [dac_ctrl_pkg::CODE_W-1:0]        broadcast_code_o
);
	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	logic [1:0] rst_sync_q;
	logic       rst_n;

	// assert at once, release two edges later to avoid metastable release
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic                                 pin_s1;
		logic                                 pin_s2;
		logic [dac_ctrl_pkg::REG_W-1:0]       accept;
		logic [dac_ctrl_pkg::REG_W-1:0]       soft_clr;
		logic [dac_ctrl_pkg::REG_W-1:0]       pin_ignore;
		logic [dac_ctrl_pkg::CODE_W-1:0]      clr_code;
		logic [dac_ctrl_pkg::REG_W-1:0]       rdata;
		logic                                 rvalid;
		logic [dac_ctrl_pkg::CHANNELS-1:0]    clr_act;
		logic [dac_ctrl_pkg::ALL_CODES_W-1:0] dac_code;
		logic [dac_ctrl_pkg::CHANNELS-1:0]    bc_load;
		logic [dac_ctrl_pkg::CODE_W-1:0]      bc_code;
	} ctrl_s;

	ctrl_s r_q;
	ctrl_s r_d;

	logic [dac_ctrl_pkg::CHANNELS-1:0]    code_wr_en;
	logic [dac_ctrl_pkg::ALL_CODES_W-1:0] stored_codes;

	// address match, shared by the write and read decoders
	function automatic logic hit(input logic [dac_ctrl_pkg::ADDR_W-1:0] a,
	                             input logic [dac_ctrl_pkg::ADDR_W-1:0] ofs);
		hit = (a == ofs);
	endfunction : hit

	// ----------------------------------------------------------------
	// clear code storage
	// ----------------------------------------------------------------
	// only accepting channels see the broadcast clear code write
	assign code_wr_en = {dac_ctrl_pkg::CHANNELS{reg_wr_i &&
		hit(reg_addr_i, dac_ctrl_pkg::BROADCAST_CLEAR_CODE_OFS)}} & r_q.accept; // RULE8 RULE1

	clear_code_store u_store (
		.mclk_i    (mclk_i),
		.rst_n_i   (rst_n),
		.wr_en_i   (code_wr_en),
		.wr_code_i (reg_wdata_i[dac_ctrl_pkg::CODE_FIELD_MSB:dac_ctrl_pkg::CODE_FIELD_LSB]),
		.codes_o   (stored_codes)
	);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	// one write per cycle; reads answer one cycle later, unmapped reads zero
	always_comb begin
		r_d        = r_q;
		r_d.pin_s1 = multi_function_pin_i;
		r_d.pin_s2 = r_q.pin_s1;
		if (reg_wr_i) begin
			if (hit(reg_addr_i, dac_ctrl_pkg::BROADCAST_ACCEPT_MASK_OFS)) begin
				r_d.accept = reg_wdata_i; // RULE3
			end else if (hit(reg_addr_i, dac_ctrl_pkg::CHANNEL_SOFT_CLEAR_OFS)) begin
				r_d.soft_clr = reg_wdata_i; // RULE4 RULE5 RULE7
			end else if (hit(reg_addr_i, dac_ctrl_pkg::CLEAR_PIN_IGNORE_OFS)) begin
				r_d.pin_ignore = reg_wdata_i; // RULE9
			end else if (hit(reg_addr_i, dac_ctrl_pkg::BROADCAST_CLEAR_CODE_OFS)) begin
				r_d.clr_code = reg_wdata_i[dac_ctrl_pkg::CODE_FIELD_MSB:dac_ctrl_pkg::CODE_FIELD_LSB];
			end
		end
		r_d.rvalid = reg_rd_i;
		r_d.rdata  = dac_ctrl_pkg::READ_ZERO;
		if (reg_rd_i) begin
			if (hit(reg_addr_i, dac_ctrl_pkg::BROADCAST_ACCEPT_MASK_OFS)) begin
				r_d.rdata = r_q.accept;
			end else if (hit(reg_addr_i, dac_ctrl_pkg::CHANNEL_SOFT_CLEAR_OFS)) begin
				r_d.rdata = r_q.soft_clr;
			end else if (hit(reg_addr_i, dac_ctrl_pkg::CLEAR_PIN_IGNORE_OFS)) begin
				r_d.rdata = r_q.pin_ignore;
			end else if (hit(reg_addr_i, dac_ctrl_pkg::BROADCAST_CLEAR_CODE_OFS)) begin
				r_d.rdata = {r_q.clr_code, dac_ctrl_pkg::CODE_RSVD_BITS}; // reserved low bits
			end
		end
		// each channel decides alone; kept in this process to avoid a loop through r_d
		for (int n = 0; n < dac_ctrl_pkg::CHANNELS; n++) begin
			r_d.clr_act[n] = r_d.soft_clr[n] ||
				(r_q.pin_s2 && !r_d.pin_ignore[n]); // RULE5 RULE7 RULE9 RULE10
			r_d.dac_code[n*dac_ctrl_pkg::CODE_W +: dac_ctrl_pkg::CODE_W] = r_d.clr_act[n] ?
				stored_codes[n*dac_ctrl_pkg::CODE_W +: dac_ctrl_pkg::CODE_W] :
				data_code_i[n*dac_ctrl_pkg::CODE_W +: dac_ctrl_pkg::CODE_W]; // RULE6
		end
		// data broadcast strobes go only to accepting channels
		r_d.bc_load = {dac_ctrl_pkg::CHANNELS{broadcast_data_wr_i}} & r_q.accept; // RULE1 RULE2
		r_d.bc_code = broadcast_data_i;
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			r_q.pin_s1     <= 1'b0;
			r_q.pin_s2     <= 1'b0;
			r_q.accept     <= dac_ctrl_pkg::BROADCAST_ACCEPT_RST; // RULE3
			r_q.soft_clr   <= dac_ctrl_pkg::SOFT_CLEAR_RST; // RULE4
			r_q.pin_ignore <= dac_ctrl_pkg::PIN_IGNORE_RST;
			r_q.clr_code   <= dac_ctrl_pkg::CLEAR_CODE_RST;
			r_q.rdata      <= dac_ctrl_pkg::READ_ZERO;
			r_q.rvalid     <= 1'b0;
			r_q.clr_act    <= '0;
			r_q.dac_code   <= '0;
			r_q.bc_load    <= '0;
			r_q.bc_code    <= dac_ctrl_pkg::CLEAR_CODE_RST;
		end else begin
			r_q <= r_d;
		end
	end

	assign reg_rdata_o      = r_q.rdata;
	assign reg_rvalid_o     = r_q.rvalid;
	assign clear_active_o   = r_q.clr_act;
	assign dac_code_o       = r_q.dac_code;
	assign broadcast_load_o = r_q.bc_load;
	assign broadcast_code_o = r_q.bc_code;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n);

	bcast_gate_on_a: assert property (broadcast_data_wr_i |=>
		broadcast_load_o == $past(r_q.accept)) // RULE2
		else $error("broadcast load does not follow accept mask");
	bcast_idle_a: assert property (!broadcast_data_wr_i |=> broadcast_load_o == '0) // RULE1
		else $error("broadcast load without a broadcast write");
	accept_read_a: assert property ((reg_rd_i &&
		hit(reg_addr_i, dac_ctrl_pkg::BROADCAST_ACCEPT_MASK_OFS)) |=>
		reg_rvalid_o && reg_rdata_o == $past(r_q.accept)) // RULE3
		else $error("accept mask read back wrong");
	soft_clear_wr_a: assert property ((reg_wr_i && !r_q.pin_s2 &&
		hit(reg_addr_i, dac_ctrl_pkg::CHANNEL_SOFT_CLEAR_OFS)) |=>
		clear_active_o == $past(reg_wdata_i)) // RULE5
		else $error("soft clear write not reflected in clear state");
	clear_src_a: assert property (clear_active_o[0] |->
		dac_code_o[11:0] == $past(stored_codes[11:0])) // RULE6
		else $error("cleared channel not driving clear code");
	// the first edge out of reset still shows the reset code, so skip it
	normal_src_a: assert property ((!clear_active_o[15] && $past(rst_n)) |->
		dac_code_o[191:180] == $past(data_code_i[191:180])) // RULE7
		else $error("normal channel not driving data code");
	code_load_a: assert property ((reg_wr_i && r_q.accept[0] &&
		hit(reg_addr_i, dac_ctrl_pkg::BROADCAST_CLEAR_CODE_OFS)) |=>
		stored_codes[11:0] == $past(reg_wdata_i[15:4])) // RULE8
		else $error("broadcast clear code not loaded");
	code_hold_a: assert property (!r_q.accept[3] |=> $stable(stored_codes[47:36])) // RULE1
		else $error("non accepting channel clear code changed");
	pin_mask_a: assert property (clear_active_o[8] |->
		(r_q.soft_clr[8] || (!r_q.pin_ignore[8] && $past(r_q.pin_s2)))) // RULE9
		else $error("clear state without a cause");

	// read back and write paths of the two main registers
	clear_read_a: assert property ((reg_rd_i &&
		hit(reg_addr_i, dac_ctrl_pkg::CHANNEL_SOFT_CLEAR_OFS)) |=>
		reg_rvalid_o && reg_rdata_o == $past(r_q.soft_clr)) // RULE4
		else $error("soft clear read back wrong");
	soft_release_a: assert property ((reg_wr_i && !r_q.pin_s2 && !reg_wdata_i[4] &&
		hit(reg_addr_i, dac_ctrl_pkg::CHANNEL_SOFT_CLEAR_OFS)) |=>
		!clear_active_o[4]) // RULE7
		else $error("soft clear release not reflected");
	accept_write_a: assert property ((reg_wr_i &&
		hit(reg_addr_i, dac_ctrl_pkg::BROADCAST_ACCEPT_MASK_OFS)) |=>
		r_q.accept == $past(reg_wdata_i)) // RULE3
		else $error("accept mask write lost");
	// clear pin reaches exactly the channels that do not ignore it
	pin_ignored_a: assert property ((r_q.pin_ignore[0] && !r_q.soft_clr[0]) |->
		!clear_active_o[0]) // RULE9
		else $error("ignored channel cleared by pin");
	pin_clear_a: assert property (($past(r_q.pin_s2) && !r_q.pin_ignore[15]) |->
		clear_active_o[15]) // RULE9
		else $error("pin did not clear a listening channel");
	bc_code_a: assert property (broadcast_data_wr_i |=>
		broadcast_code_o == $past(broadcast_data_i)) // RULE2
		else $error("broadcast code not passed on");
endmodule : dac_channel_ctrl
`default_nettype wire

/* File: rtl/dac_ctrl_pkg.sv */
// shared constants for the channel broadcast and soft clear control block
`default_nettype none
package dac_ctrl_pkg;
	// ----------------------------------------------------------------
	// geometry
	// ----------------------------------------------------------------
	localparam int unsigned CHANNELS    = 16;
	localparam int unsigned CODE_W      = 12;
	localparam int unsigned REG_W       = 16;
	localparam int unsigned ADDR_W      = 4;
	localparam int unsigned ALL_CODES_W = CHANNELS * CODE_W;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] BROADCAST_ACCEPT_MASK_OFS = 4'hB;
	localparam logic [ADDR_W-1:0] CHANNEL_SOFT_CLEAR_OFS    = 4'hC;
	localparam logic [ADDR_W-1:0] CLEAR_PIN_IGNORE_OFS      = 4'hD;
	localparam logic [ADDR_W-1:0] BROADCAST_CLEAR_CODE_OFS  = 4'hE;

	// ----------------------------------------------------------------
	// reset values and field layout
	// ----------------------------------------------------------------
	localparam logic [REG_W-1:0]  BROADCAST_ACCEPT_RST = 16'hFFFF;
	localparam logic [REG_W-1:0]  SOFT_CLEAR_RST       = 16'h0000;
	localparam logic [REG_W-1:0]  PIN_IGNORE_RST       = 16'h0000;
	localparam logic [CODE_W-1:0] CLEAR_CODE_RST       = 12'h000;
	localparam logic [REG_W-1:0]  READ_ZERO            = 16'h0000;
	localparam logic [3:0]        CODE_RSVD_BITS       = 4'h0;
	localparam int unsigned       CODE_FIELD_LSB       = 4;
	localparam int unsigned       CODE_FIELD_MSB       = 15;
endpackage : dac_ctrl_pkg
`default_nettype wire

/* File: rtl/clear_code_store.sv */
// per-channel clear code storage with a write enable per channel
`default_nettype none
module clear_code_store (
	input  wire logic                                   mclk_i,
	input  wire logic                                   rst_n_i,
	input  wire logic [dac_ctrl_pkg::CHANNELS-1:0]      wr_en_i,
	input  wire logic [dac_ctrl_pkg::CODE_W-1:0]        wr_code_i,
	output logic      [dac_ctrl_pkg::ALL_CODES_W-1:0]   codes_o
);
	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [dac_ctrl_pkg::ALL_CODES_W-1:0] codes;
	} store_s;

	store_s r_q;
	store_s r_d;

	// each enabled channel takes the shared code, others hold
	always_comb begin
		r_d = r_q;
		for (int n = 0; n < dac_ctrl_pkg::CHANNELS; n++) begin
			if (wr_en_i[n]) begin
				r_d.codes[n*dac_ctrl_pkg::CODE_W +: dac_ctrl_pkg::CODE_W] = wr_code_i;
			end
		end
	end

	// register the whole array; read data is the registered contents
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			r_q.codes <= {dac_ctrl_pkg::CHANNELS{dac_ctrl_pkg::CLEAR_CODE_RST}};
		end else begin
			r_q <= r_d;
		end
	end

	assign codes_o = r_q.codes;
endmodule : clear_code_store
`default_nettype wire

/* File: sim/host_model.sv */
// host side driver of the register strobe port
`default_nettype none
module host_model (
	input  wire logic        mclk_i,
	output logic             reg_wr_o,
	output logic             reg_rd_o,
	output logic [3:0]       reg_addr_o,
	output logic [15:0]      reg_wdata_o,
	input  wire logic [15:0] reg_rdata_i,
	input  wire logic        reg_rvalid_i
);
	timeunit 1ns;
	timeprecision 1ps;
	// strobes idle low from time zero
	initial begin
		reg_wr_o    = 1'b0;
		reg_rd_o    = 1'b0;
		reg_addr_o  = 4'h0;
		reg_wdata_o = 16'h0000;
	end
	// one write, held over one rising edge
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(negedge mclk_i);
		reg_addr_o  = a;
		reg_wdata_o = d;
		reg_wr_o    = 1'b1;
		@(negedge mclk_i);
		reg_wr_o    = 1'b0;
		reg_wdata_o = ~d;  // released data shows no stale value
	endtask : wr
	// one read; the answer stands only in the cycle after the strobe, take it there
	task automatic rd(input logic [3:0] a, output logic [15:0] d, output logic v);
		@(negedge mclk_i);
		reg_addr_o = a;
		reg_rd_o   = 1'b1;
		@(negedge mclk_i);
		d          = reg_rdata_i;
		v          = reg_rvalid_i;
		reg_rd_o   = 1'b0;
	endtask : rd
endmodule : host_model
`default_nettype wire

/* File: sim/tb_dac_bcast_mask_soft_clear.sv */
// self-checking bench for the broadcast accept and soft clear block
`default_nettype none
module tb_dac_bcast_mask_soft_clear;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic [3:0] a; logic [15:0] d; logic [15:0] e;} row_s;
	// writes and their read back; unmapped offset 3 reads zero
	localparam row_s ROWS [7] = '{
		'{4'hB, 16'hA5A5, 16'hA5A5}, '{4'hC, 16'h0001, 16'h0001},
		'{4'hC, 16'h0000, 16'h0000}, '{4'hD, 16'h8001, 16'h8001},
		'{4'hD, 16'h0000, 16'h0000}, '{4'hE, 16'hABCD, 16'hABC0},
		'{4'h3, 16'h1234, 16'h0000}};
	logic mclk = 1'b0, nrst = 1'b0, pin, bwr, wr, rd, rv, v;
	logic [3:0] addr;
	logic [11:0] bcode, bcode_o;
	logic [15:0] wdata, rdata, clr, bload, got;
	logic [191:0] dcode, dac;
	int n_mismatch = 0, total_checks = 0;
	always #10 mclk = ~mclk;
	dac_channel_ctrl u_dut (.mclk_i(mclk), .nrst_i(nrst), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .multi_function_pin_i(pin),
		.broadcast_data_wr_i(bwr), .broadcast_data_i(bcode), .data_code_i(dcode),
		.reg_rdata_o(rdata), .reg_rvalid_o(rv), .clear_active_o(clr), .dac_code_o(dac),
		.broadcast_load_o(bload), .broadcast_code_o(bcode_o));
	host_model u_host (.mclk_i(mclk), .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(addr),
		.reg_wdata_o(wdata), .reg_rdata_i(rdata), .reg_rvalid_i(rv));
	task automatic cmpc(input logic [191:0] g, input logic [191:0] e);
		total_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch at %0t got %h exp %h", $time, g, e);
		end
	endtask : cmpc
	task automatic cmp16(input logic [15:0] g, input logic [15:0] e);
		cmpc({176'h0, g}, {176'h0, e});
	endtask : cmp16
	// cleared accepting channels show code ABC, cleared others 000
	function automatic logic [191:0] exp_codes(input logic [15:0] m, input logic [15:0] c);
		logic [191:0] r;
		for (int n = 0; n < 16; n++) begin
			r[n*12+:12] = c[n] ? (m[n] ? 12'hABC : 12'h000) : dcode[n*12+:12];
		end
		return r;
	endfunction : exp_codes
	task automatic bcast(input logic [15:0] m);
		@(negedge mclk);
		bcode = 12'h123;
		bwr = 1'b1;
		@(negedge mclk);
		cmp16(bload, m);
		cmp16({4'h0, bcode_o}, 16'h0123);
		bwr = 1'b0;
		bcode = 12'hEDC;
		@(negedge mclk);
		cmp16(bload, 16'h0000);
	endtask : bcast
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : summarize
	// a hang ends the run as a failure
	initial begin
		#200us;
		n_mismatch++;
		summarize();
	end
	initial begin
		pin = 1'b0;
		bwr = 1'b0;
		bcode = 12'h000;
		for (int n = 0; n < 16; n++) begin
			dcode[n*12+:12] = 12'h100 + 12'(n);
		end
		repeat (2) @(negedge mclk);
		cmpc(dac, 192'h0);
		nrst = 1'b1;
		repeat (3) @(negedge mclk);
		cmpc(dac, dcode);
		u_host.rd(4'hB, got, v);
		cmp16(got, 16'hFFFF);
		u_host.rd(4'hC, got, v);
		cmp16(got, 16'h0000);
		foreach (ROWS[i]) begin
			u_host.wr(ROWS[i].a, ROWS[i].d);
			u_host.rd(ROWS[i].a, got, v);
			cmp16(got, ROWS[i].e);
			cmp16({15'h0, v}, 16'h0001);
		end
		// mask A5A5 held while the clear code went in
		u_host.wr(4'hC, 16'hFFFF);
		@(negedge mclk);
		cmp16(clr, 16'hFFFF);
		cmpc(dac, exp_codes(16'hA5A5, 16'hFFFF));
		u_host.wr(4'hC, 16'h0004);
		@(negedge mclk);
		cmpc(dac, exp_codes(16'hA5A5, 16'h0004));
		u_host.wr(4'hC, 16'h0000);
		@(negedge mclk);
		cmpc(dac, dcode);
		cmp16(clr, 16'h0000);
		bcast(16'hA5A5);
		u_host.wr(4'hB, 16'h0000);
		bcast(16'h0000);
		u_host.wr(4'hB, 16'hFFFF);
		bcast(16'hFFFF);
		// clear pin reaches only channels not ignoring it
		u_host.wr(4'hD, 16'h00FF);
		pin = 1'b1;
		repeat (4) @(negedge mclk);
		cmp16(clr, 16'hFF00);
		pin = 1'b0;
		repeat (4) @(negedge mclk);
		cmp16(clr, 16'h0000);
		// mid-run reset must bring the accept mask, soft clear and clear code registers back to their reset values
		u_host.wr(4'hC, 16'h0F0F);
		u_host.wr(4'hB, 16'h1234);
		@(negedge mclk);
		cmp16(clr, 16'h0F0F);
		nrst = 1'b0;
		@(negedge mclk);
		cmp16(clr, 16'h0000);
		cmpc(dac, 192'h0);
		nrst = 1'b1;
		repeat (3) @(negedge mclk);
		cmpc(dac, dcode);
		u_host.rd(4'hB, got, v);
		cmp16(got, 16'hFFFF);
		u_host.rd(4'hC, got, v);
		cmp16(got, 16'h0000);
		u_host.rd(4'hE, got, v);
		cmp16(got, 16'h0000);
		summarize();
	end
endmodule : tb_dac_bcast_mask_soft_clear
`default_nettype wire
